//--- design/bmrm_defs.svh
// Offsets, field positions, reset values and limits of the rate match block
`ifndef BMRM_DEFS_SVH
`define BMRM_DEFS_SVH

// ************************************************
// Register map
// ************************************************
`define BMRM_OFS_CTRL 8'h00
`define BMRM_OFS_STAT 8'h04
`define BMRM_OFS_SKIP 8'h08
`define BMRM_RESP_OK 2'h0
`define BMRM_RESP_ERR 2'h2

// ************************************************
// Fields
// ************************************************
`define BMRM_CTL_LOWLAT 0
`define BMRM_CTL_PMA10 1
`define BMRM_CTL_CODEC 2
`define BMRM_CTL_EIDLE 3
`define BMRM_CTRL_RST 4'h6
`define BMRM_ST_FULL 0
`define BMRM_ST_EMPTY 1
`define BMRM_ST_SIGDET 2
`define BMRM_ST_LVL 8

// ************************************************
// Characters and limits
// ************************************************
`define BMRM_SKIP_RST 9'h11c
`define BMRM_PAD_CHAR 9'h1fe
`define BMRM_MAX_DEL 3'h4
`define BMRM_MAX_INS 3'h4
`define BMRM_CLUS_LIM 3'h5
`define BMRM_HI_WM 5'h0c
`define BMRM_LO_WM 5'h04

`endif

//--- design/bmrm_pkg.sv
// Types shared by the rate match block
package bmrm_pkg;
   typedef struct packed {
      logic full_tag;
      logic [8:0] chr;
   } bmrm_ent_type;

   typedef enum logic [1:0] {
      WS_IDLE = 2'b01,
      WS_RESP = 2'b10
   } bmrm_wst_type;
endpackage : bmrm_pkg

//--- design/bmrm_fifo.sv
// Flip-flop FIFO with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
module bmrm_fifo #(
   parameter int WIDTH = 10,
   parameter int DEPTH = 16,
   parameter int AW = 4
) (
   input wire logic mclk_i,
   input wire logic rst_b_i,
   input wire logic in_valid_i,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic in_ready_o,
   output logic out_valid_o,
   output logic [WIDTH-1:0] out_data_o,
   input wire logic out_ready_i,
   output logic [AW:0] count_o
);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wp_r;
   logic [AW-1:0] rp_r;
   logic [AW:0] cnt_r;
   logic push;
   logic pop;

   // Depth needs the extra count bit; an AW-bit cast of it would wrap to zero
   assign in_ready_o = (cnt_r != (AW+1)'(DEPTH));
   assign out_valid_o = (cnt_r != '0);
   assign out_data_o = mem_r[rp_r];
   assign count_o = cnt_r;
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   always_ff @(posedge mclk_i) begin
      if (push) begin
         mem_r[wp_r] <= in_data_i;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end else begin
         if (push) begin
            wp_r <= (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
         end
         if (pop) begin
            rp_r <= (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
         end
         cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : bmrm_fifo
`default_nettype wire

//--- design/bmrm_top.sv
// Receive rate match path with low-latency bypass, idle and detect control
`timescale 1ns/100ps
`default_nettype none
`include "bmrm_defs.svh"

module bmrm_top
   import bmrm_pkg::*;
#(
   parameter int DEPTH = 16,
   parameter int AW = 4
) (
   input wire logic mclk_i,
   input wire logic rst_b_i,
   input wire logic [7:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic [7:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   input wire logic in_valid_i,
   input wire logic [9:0] in_word_i,
   output logic in_ready_o,
   input wire logic rd_req_i,
   output logic out_valid_o,
   output logic [9:0] out_word_o,
   output logic out_full_o,
   output logic out_empty_o,
   input wire logic rx_sigdet_i,
   output logic sigdet_o,
   input wire logic tx_bit_i,
   output logic tx_p_o,
   output logic tx_p_oe_o
);
   // ************************************************
   // Declarations
   // ************************************************
   logic [3:0] ctrl_r;
   logic [8:0] skip_r;
   logic full_seen_r;
   logic empty_seen_r;
   bmrm_wst_type wst_r;
   logic aw_hold_r;
   logic w_hold_r;
   logic [7:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic [1:0] bresp_r;
   logic rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0] rresp_r;
   logic sd_s1_r;
   logic sd_s2_r;
   logic lowlat;
   logic [8:0] chr_in;
   logic is_skip;
   logic [2:0] wkeep_r;
   logic [2:0] wdel_r;
   logic del_ok;
   logic full_pend_r;
   logic drop;
   bmrm_ent_type wr_ent;
   bmrm_ent_type head;
   logic f_in_valid;
   logic f_in_ready;
   logic f_out_valid;
   logic [9:0] f_out_data;
   logic pop;
   logic [AW:0] level;
   logic last_skip_r;
   logic [2:0] rrun_r;
   logic [2:0] rins_r;
   logic ins_ok;
   logic do_wr;
   logic ev_full;
   logic ev_empty;

   // Decodes an offset; shared by both channels
   function automatic logic [2:0] reg_sel(input logic [7:0] a);
      reg_sel = 3'b000;
      case (a)
         `BMRM_OFS_CTRL: reg_sel = 3'b001;
         `BMRM_OFS_STAT: reg_sel = 3'b010;
         `BMRM_OFS_SKIP: reg_sel = 3'b100;
         default: reg_sel = 3'b000;
      endcase
   endfunction : reg_sel

   // ************************************************
   // Register bus, write side
   // ************************************************
   assign s_axi_awready_o = !aw_hold_r && (wst_r == WS_IDLE);
   assign s_axi_wready_o = !w_hold_r && (wst_r == WS_IDLE);
   assign s_axi_bvalid_o = (wst_r == WS_RESP);
   assign s_axi_bresp_o = bresp_r;
   assign do_wr = aw_hold_r && w_hold_r && (wst_r == WS_IDLE);

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wst_r <= WS_IDLE;
         aw_hold_r <= 1'b0;
         w_hold_r <= 1'b0;
         awaddr_r <= '0;
         wdata_r <= '0;
         wstrb_r <= '0;
         bresp_r <= `BMRM_RESP_OK;
      end else begin
         if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_hold_r <= 1'b1;
            awaddr_r <= s_axi_awaddr_i;
         end
         if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_hold_r <= 1'b1;
            wdata_r <= s_axi_wdata_i;
            wstrb_r <= s_axi_wstrb_i;
         end
         case (wst_r)
            WS_IDLE: begin
               if (do_wr) begin
                  aw_hold_r <= 1'b0;
                  w_hold_r <= 1'b0;
                  bresp_r <= (reg_sel(awaddr_r) == 3'b000) ? `BMRM_RESP_ERR : `BMRM_RESP_OK;
                  wst_r <= WS_RESP;
               end
            end
            WS_RESP: begin
               if (s_axi_bready_i) begin
                  wst_r <= WS_IDLE;
               end
            end
            default: wst_r <= WS_IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ctrl_r <= `BMRM_CTRL_RST;
         skip_r <= `BMRM_SKIP_RST;
      end else if (do_wr) begin
         if (reg_sel(awaddr_r) == 3'b001 && wstrb_r[0]) begin
            ctrl_r <= wdata_r[3:0];
         end
         // Pattern changes mid-cluster simply restart the count
         if (reg_sel(awaddr_r) == 3'b100) begin
            if (wstrb_r[0]) begin
               skip_r[7:0] <= wdata_r[7:0];
            end
            if (wstrb_r[1]) begin
               skip_r[8] <= wdata_r[8];
            end
         end
      end
   end

   // Sticky events; an event in the clearing cycle survives
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         full_seen_r <= 1'b0;
         empty_seen_r <= 1'b0;
      end else begin
         if (ev_full) begin
            full_seen_r <= 1'b1;
         end else if (do_wr && reg_sel(awaddr_r) == 3'b010 && wstrb_r[0]
                      && wdata_r[`BMRM_ST_FULL]) begin
            full_seen_r <= 1'b0;
         end
         if (ev_empty) begin
            empty_seen_r <= 1'b1;
         end else if (do_wr && reg_sel(awaddr_r) == 3'b010 && wstrb_r[0]
                      && wdata_r[`BMRM_ST_EMPTY]) begin
            empty_seen_r <= 1'b0;
         end
      end
   end

   // ************************************************
   // Register bus, read side
   // ************************************************
   assign s_axi_arready_o = !rvalid_r;
   assign s_axi_rvalid_o = rvalid_r;
   assign s_axi_rdata_o = rdata_r;
   assign s_axi_rresp_o = rresp_r;

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rvalid_r <= 1'b0;
         rdata_r <= '0;
         rresp_r <= `BMRM_RESP_OK;
      end else if (s_axi_arvalid_i && s_axi_arready_o) begin
         rvalid_r <= 1'b1;
         rresp_r <= `BMRM_RESP_OK;
         rdata_r <= '0;
         case (reg_sel(s_axi_araddr_i))
            3'b001: rdata_r[3:0] <= ctrl_r;
            3'b010: begin
               rdata_r[`BMRM_ST_FULL] <= full_seen_r;
               rdata_r[`BMRM_ST_EMPTY] <= empty_seen_r;
               rdata_r[`BMRM_ST_SIGDET] <= sigdet_o;
               rdata_r[`BMRM_ST_LVL +: AW+1] <= level;
            end
            3'b100: rdata_r[8:0] <= skip_r;
            default: rresp_r <= `BMRM_RESP_ERR;
         endcase
      end else if (s_axi_rready_i) begin
         rvalid_r <= 1'b0;
      end
   end

   // ************************************************
   // Signal detect and transmitter idle
   // ************************************************
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sd_s1_r <= 1'b0;
         sd_s2_r <= 1'b0;
      end else begin
         sd_s1_r <= rx_sigdet_i;
         sd_s2_r <= sd_s1_r;
      end
   end

   // Detection relies on decoded characters, so no codec means no detect
   assign sigdet_o = sd_s2_r && ctrl_r[`BMRM_CTL_CODEC] && !lowlat;

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         tx_p_o <= 1'b0;
         tx_p_oe_o <= 1'b0;
      end else begin
         tx_p_o <= tx_bit_i;
         tx_p_oe_o <= !ctrl_r[`BMRM_CTL_EIDLE];
      end
   end

   // ************************************************
   // Write side: width select, cluster tracking, deletion
   // ************************************************
   assign lowlat = ctrl_r[`BMRM_CTL_LOWLAT];
   assign chr_in = ctrl_r[`BMRM_CTL_PMA10] ? in_word_i[8:0] : {1'b0, in_word_i[7:0]};
   assign is_skip = (chr_in == skip_r);
   assign del_ok = is_skip && (wkeep_r != 3'h0) && (wdel_r < `BMRM_MAX_DEL)
                   && (level >= `BMRM_HI_WM);
   assign f_in_valid = in_valid_i && !lowlat && !del_ok;
   // Recovered data cannot stall; ready is advisory and overrun drops
   assign drop = f_in_valid && !f_in_ready;
   assign in_ready_o = lowlat || f_in_ready;
   assign wr_ent = '{full_tag: full_pend_r, chr: chr_in};
   assign ev_full = drop;

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wkeep_r <= '0;
         wdel_r <= '0;
      end else if (in_valid_i && !lowlat) begin
         if (!is_skip) begin
            wkeep_r <= '0;
            wdel_r <= '0;
         end else if (del_ok) begin
            wdel_r <= wdel_r + 3'h1;
         end else if (!drop && wkeep_r != 3'h7) begin
            wkeep_r <= wkeep_r + 3'h1;
         end
      end
   end

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         full_pend_r <= 1'b0;
      end else if (drop) begin
         full_pend_r <= 1'b1;
      end else if (f_in_valid) begin
         full_pend_r <= 1'b0;
      end
   end

   bmrm_fifo #(
      .WIDTH(10),
      .DEPTH(DEPTH),
      .AW(AW)
   ) u_fifo (
      .mclk_i(mclk_i),
      .rst_b_i(rst_b_i),
      .in_valid_i(f_in_valid),
      .in_data_i(wr_ent),
      .in_ready_o(f_in_ready),
      .out_valid_o(f_out_valid),
      .out_data_o(f_out_data),
      .out_ready_i(pop),
      .count_o(level)
   );

   // ************************************************
   // Read side: insertion, padding, bypass
   // ************************************************
   assign head = f_out_data;
   // Insert only at a cluster's end, so inserted skips stay contiguous
   assign ins_ok = last_skip_r && f_out_valid && (head.chr != skip_r)
                   && (rrun_r < `BMRM_CLUS_LIM - 3'h1) && (rins_r < `BMRM_MAX_INS)
                   && (level <= `BMRM_LO_WM);
   assign pop = rd_req_i && !lowlat && !ins_ok && f_out_valid;
   assign ev_empty = rd_req_i && !lowlat && !f_out_valid;

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         out_valid_o <= 1'b0;
         out_word_o <= '0;
         out_full_o <= 1'b0;
         out_empty_o <= 1'b0;
      end else if (lowlat) begin
         out_valid_o <= in_valid_i;
         out_word_o <= ctrl_r[`BMRM_CTL_PMA10] ? in_word_i : {2'b00, in_word_i[7:0]};
         out_full_o <= 1'b0;
         out_empty_o <= 1'b0;
      end else begin
         out_valid_o <= rd_req_i;
         out_full_o <= pop && head.full_tag;
         out_empty_o <= ev_empty;
         if (ins_ok) begin
            out_word_o <= {1'b0, skip_r};
         end else if (f_out_valid) begin
            out_word_o <= {1'b0, head.chr};
         end else begin
            out_word_o <= {1'b0, `BMRM_PAD_CHAR};
         end
      end
   end

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         last_skip_r <= 1'b0;
         rrun_r <= '0;
         rins_r <= '0;
      end else if (rd_req_i && !lowlat) begin
         if (ins_ok) begin
            rrun_r <= rrun_r + 3'h1;
            rins_r <= rins_r + 3'h1;
         end else if (pop && head.chr == skip_r) begin
            last_skip_r <= 1'b1;
            rrun_r <= (rrun_r == 3'h7) ? rrun_r : rrun_r + 3'h1;
         end else begin
            last_skip_r <= 1'b0;
            rrun_r <= '0;
            rins_r <= '0;
         end
      end
   end

   // ************************************************
   // Assertions
   // ************************************************
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_b_i);

   del_hold_a: assert property (in_valid_i && !lowlat && del_ok && !pop |=> level == $past(level)) else $error("deleted skip was stored");
   del_count_a: assert property (wdel_r <= `BMRM_MAX_DEL) else $error("too many deletions");
   ins_char_a: assert property (rd_req_i && !lowlat && ins_ok |=> out_word_o[8:0] == $past(skip_r) && out_valid_o) else $error("inserted char is not skip");
   ins_count_a: assert property (rins_r <= `BMRM_MAX_INS) else $error("too many insertions");
   full_flag_a: assert property (pop && head.full_tag |=> out_full_o && out_valid_o)
      else $error("full tag missing");
   full_pend_a: assert property (drop |=> full_pend_r) else $error("drop not remembered");
   empty_pad_a: assert property (rd_req_i && !lowlat && !f_out_valid |=> out_empty_o && out_word_o == 10'h1fe) else $error("empty pad missing");
   bypass_a: assert property (lowlat |-> !f_in_valid && !pop) else $error("FIFO used in bypass");
   bypass_dat_a: assert property (lowlat && in_valid_i && ctrl_r[`BMRM_CTL_PMA10] |=> out_word_o == $past(in_word_i)) else $error("bypass word wrong");
   eidle_a: assert property (ctrl_r[`BMRM_CTL_EIDLE] ##1 ctrl_r[`BMRM_CTL_EIDLE] |-> !tx_p_oe_o) else $error("driver on in idle");
   sigdet_a: assert property (!ctrl_r[`BMRM_CTL_CODEC] |-> !sigdet_o) else $error("detect without codec");
   width8_a: assert property (!ctrl_r[`BMRM_CTL_PMA10] && lowlat |=> out_word_o[9:8] == 2'b00) else $error("upper bits in 8-bit mode");

   delete_c: cover property (in_valid_i && !lowlat && del_ok);
   insert_c: cover property (rd_req_i && !lowlat && ins_ok);
   overrun_c: cover property (drop ##[1:20] out_full_o);
   underrun_c: cover property (ev_empty ##1 out_empty_o);
endmodule : bmrm_top
`default_nettype wire

//--- test/bmrm_fab.sv
// Fabric-side reader model: issues a set number of read requests, logs outputs
`timescale 1ns/100ps
`default_nettype none
module bmrm_fab (
   input wire logic mclk_i,
   input wire logic rst_b_i,
   input wire logic go_i,
   input wire logic [5:0] n_i,
   input wire logic slow_i,
   output logic rd_req_o,
   output logic busy_o,
   input wire logic out_valid_i,
   input wire logic [9:0] out_word_i,
   input wire logic out_full_i,
   input wire logic out_empty_i
);
   // ************************************************
   // Request pacing
   // ************************************************
   logic [5:0] left_r;
   logic ph_r;
   logic [11:0] q[$];
   // Slow mode asks every other cycle, like a busy consumer
   assign rd_req_o = (left_r != 6'h00) && (!slow_i || ph_r);
   assign busy_o = left_r != 6'h00;
   always @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         left_r <= 6'h00;
         ph_r <= 1'b0;
      end else begin
         ph_r <= ~ph_r;
         if (go_i) begin
            left_r <= n_i;
         end else if (rd_req_o) begin
            left_r <= left_r - 6'h01;
         end
      end
   end
   // ************************************************
   // Output log
   // ************************************************
   always @(posedge mclk_i) begin
      if (out_valid_i) begin
         q.push_back({out_full_i, out_empty_i, out_word_i});
      end
   end
endmodule : bmrm_fab
`default_nettype wire

//--- test/testbench.sv
// Register, stream and option tests of the rate match block
`timescale 1ns/100ps
`default_nettype none
`include "bmrm_defs.svh"
module testbench;
   import bmrm_pkg::*;
   logic mclk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic [7:0] aw_a = 8'h00;
   logic [7:0] ar_a = 8'h00;
   logic [31:0] w_d = 32'h0;
   logic [31:0] rdata;
   logic aw_v = 1'b0, w_v = 1'b0, b_rdy = 1'b0, ar_v = 1'b0, r_rdy = 1'b0;
   logic aw_rdy, w_rdy, b_v, ar_rdy, r_v;
   logic [1:0] bresp, rresp;
   logic in_v = 1'b0, rx_sd = 1'b0, tx_bit = 1'b0, go = 1'b0, slow = 1'b0;
   logic [9:0] in_w = 10'h000;
   logic [5:0] n_rd = 6'h00;
   logic in_rdy, rd_req, out_v, out_f, out_e, sigdet, tx_p, tx_oe, busy;
   logic [9:0] out_w;
   logic [9:0] fw[$];
   int bad_count = 0;
   int n_checks = 0;
   int j;
   int k;

   always #5 mclk_i = ~mclk_i;
   always @(posedge mclk_i) tx_bit <= ~tx_bit;

   bmrm_top dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .s_axi_awaddr_i(aw_a),
      .s_axi_awvalid_i(aw_v), .s_axi_awready_o(aw_rdy), .s_axi_wdata_i(w_d),
      .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(w_v), .s_axi_wready_o(w_rdy),
      .s_axi_bresp_o(bresp), .s_axi_bvalid_o(b_v), .s_axi_bready_i(b_rdy),
      .s_axi_araddr_i(ar_a), .s_axi_arvalid_i(ar_v), .s_axi_arready_o(ar_rdy),
      .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(r_v),
      .s_axi_rready_i(r_rdy), .in_valid_i(in_v), .in_word_i(in_w), .in_ready_o(in_rdy),
      .rd_req_i(rd_req), .out_valid_o(out_v), .out_word_o(out_w), .out_full_o(out_f),
      .out_empty_o(out_e), .rx_sigdet_i(rx_sd), .sigdet_o(sigdet), .tx_bit_i(tx_bit),
      .tx_p_o(tx_p), .tx_p_oe_o(tx_oe));

   bmrm_fab u_fab (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .go_i(go), .n_i(n_rd),
      .slow_i(slow), .rd_req_o(rd_req), .busy_o(busy), .out_valid_i(out_v),
      .out_word_i(out_w), .out_full_i(out_f), .out_empty_i(out_e));

   // ************************************************
   // Shared tasks
   // ************************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic [1:0] r;
      r = 2'h3;
      aw_a <= a;
      w_d <= d;
      aw_v <= 1'b1;
      w_v <= 1'b1;
      b_rdy <= 1'b1;
      for (int i = 0; i < 100; i++) begin
         @(posedge mclk_i);
         if (aw_v && aw_rdy) aw_v <= 1'b0;
         if (w_v && w_rdy) w_v <= 1'b0;
         if (b_v && b_rdy) begin
            r = bresp;
            b_rdy <= 1'b0;
            break;
         end
      end
      @(posedge mclk_i);
      chk({30'h0, r}, {30'h0, er});
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                     input logic [1:0] er);
      logic [31:0] d;
      logic [1:0] r;
      d = 32'hffffffff;
      r = 2'h3;
      ar_a <= a;
      ar_v <= 1'b1;
      r_rdy <= 1'b1;
      for (int i = 0; i < 100; i++) begin
         @(posedge mclk_i);
         if (ar_v && ar_rdy) ar_v <= 1'b0;
         if (r_v && r_rdy) begin
            d = rdata;
            r = rresp;
            r_rdy <= 1'b0;
            break;
         end
      end
      @(posedge mclk_i);
      chk(d & m, e);
      chk({30'h0, r}, {30'h0, er});
   endtask : rd

   // Whole burst in one task so in_v is never lowered and raised in one step
   task automatic feed();
      foreach (fw[i]) begin
         in_v <= 1'b1;
         in_w <= fw[i];
         @(posedge mclk_i);
      end
      in_v <= 1'b0;
      fw.delete();
   endtask : feed

   function automatic void add(input logic [9:0] b, input int n, input bit inc);
      for (int i = 0; i < n; i++) fw.push_back(inc ? b + 10'(i) : b);
   endfunction : add

   task automatic drain(input int n, input logic s);
      int i;
      u_fab.q.delete();
      n_rd <= 6'(n);
      slow <= s;
      go <= 1'b1;
      @(posedge mclk_i);
      go <= 1'b0;
      i = 0;
      do begin
         @(posedge mclk_i);
         i++;
      end while (busy && i < 200);
      repeat (3) @(posedge mclk_i);
   endtask : drain

   function automatic int nskip();
      nskip = 0;
      foreach (u_fab.q[i]) if (u_fab.q[i][8:0] === `BMRM_SKIP_RST) nskip++;
   endfunction : nskip

   task results;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : results

   // ************************************************
   // Tests
   // ************************************************
   initial begin
      repeat (20) @(posedge mclk_i);
      chk({31'h0, tx_oe}, 32'h0);
      rst_b_i <= 1'b1;
      @(posedge mclk_i);
      rd(`BMRM_OFS_CTRL, 32'hf, 32'h6, `BMRM_RESP_OK);
      rd(`BMRM_OFS_SKIP, 32'h1ff, 32'h11c, `BMRM_RESP_OK);
      rd(8'h0c, 32'hffffffff, 32'h0, `BMRM_RESP_ERR);
      wr(8'h0c, 32'h1, `BMRM_RESP_ERR);
      wr(`BMRM_OFS_CTRL, 32'h4, `BMRM_RESP_OK);
      rd(`BMRM_OFS_CTRL, 32'hf, 32'h4, `BMRM_RESP_OK);
      wr(`BMRM_OFS_CTRL, 32'h6, `BMRM_RESP_OK);
      $display("test registers done");
      add(10'h000, 17, 1);
      feed();
      @(negedge mclk_i);
      chk({31'h0, in_rdy}, 32'h0);
      rd(`BMRM_OFS_STAT, 32'h1f01, 32'h1001, `BMRM_RESP_OK);
      drain(1, 1'b0);
      add(10'h020, 1, 0);
      feed();
      drain(16, 1'b1);
      chk(u_fab.q.size(), 16);
      chk({20'h0, u_fab.q[0][11:10], u_fab.q[0][8:0]}, 32'h001);
      chk({20'h0, u_fab.q[14][11:10], u_fab.q[14][8:0]}, 32'h00f);
      chk({20'h0, u_fab.q[15][11:10], u_fab.q[15][8:0]}, 32'h420);
      wr(`BMRM_OFS_STAT, 32'h1, `BMRM_RESP_OK);
      rd(`BMRM_OFS_STAT, 32'h1, 32'h0, `BMRM_RESP_OK);
      $display("test full done");
      add(10'h040, 12, 1);
      add(10'h11c, 6, 0);
      add(10'h07f, 1, 0);
      feed();
      // Four of six skips deleted: 12 data, 2 skips, 1 data stored
      rd(`BMRM_OFS_STAT, 32'h1f00, 32'hf00, `BMRM_RESP_OK);
      // Low level on readout pads the cluster back up to four skips
      drain(17, 1'b0);
      chk(nskip(), 4);
      chk(u_fab.q.size(), 17);
      chk({23'h0, u_fab.q[16][8:0]}, 32'h07f);
      $display("test delete done");
      add(10'h030, 1, 0);
      add(10'h11c, 1, 0);
      add(10'h031, 1, 0);
      feed();
      drain(8, 1'b0);
      k = nskip();
      chk(k, 4);
      j = 0;
      foreach (u_fab.q[i]) if (u_fab.q[i][8:0] === 9'h031) j = i;
      chk(j, k + 1);
      chk({21'h0, u_fab.q[j][10], u_fab.q[j + 1][10], u_fab.q[j + 1][8:0]},
          {21'h0, 2'b01, `BMRM_PAD_CHAR});
      rd(`BMRM_OFS_STAT, 32'h2, 32'h2, `BMRM_RESP_OK);
      $display("test insert and empty done");
      rx_sd <= 1'b1;
      wr(`BMRM_OFS_CTRL, 32'h1, `BMRM_RESP_OK);
      u_fab.q.delete();
      add(10'h3a5, 1, 0);
      add(10'h11c, 3, 0);
      add(10'h25a, 1, 0);
      feed();
      repeat (3) @(posedge mclk_i);
      chk(u_fab.q.size(), 5);
      // Eight-bit interface: bypass keeps only the low byte
      chk({22'h0, u_fab.q[0][9:0]}, 32'h0a5);
      chk({22'h0, u_fab.q[4][9:0]}, 32'h05a);
      chk({30'h0, in_rdy, sigdet}, 32'h2);
      wr(`BMRM_OFS_CTRL, 32'h3, `BMRM_RESP_OK);
      u_fab.q.delete();
      add(10'h3a5, 1, 0);
      feed();
      repeat (3) @(posedge mclk_i);
      chk(u_fab.q.size(), 1);
      chk({22'h0, u_fab.q[0][9:0]}, 32'h3a5);
      wr(`BMRM_OFS_CTRL, 32'h2, `BMRM_RESP_OK);
      repeat (4) @(posedge mclk_i);
      chk({31'h0, sigdet}, 32'h0);
      wr(`BMRM_OFS_CTRL, 32'h6, `BMRM_RESP_OK);
      repeat (4) @(posedge mclk_i);
      chk({31'h0, sigdet}, 32'h1);
      rd(`BMRM_OFS_STAT, 32'h4, 32'h4, `BMRM_RESP_OK);
      $display("test bypass and detect done");
      wr(`BMRM_OFS_CTRL, 32'he, `BMRM_RESP_OK);
      repeat (2) @(posedge mclk_i);
      chk({31'h0, tx_oe}, 32'h0);
      wr(`BMRM_OFS_CTRL, 32'h6, `BMRM_RESP_OK);
      repeat (2) @(posedge mclk_i);
      chk({31'h0, tx_oe}, 32'h1);
      $display("test idle done");
      results();
   end

   // Whole run is a few hundred cycles; this leaves wide margin
   initial begin
      #400000;
      bad_count++;
      results();
   end
endmodule : testbench
`default_nettype wire
